/* File: rtl/psc_defines.svh */
/*
 Constants for the power state controller: timing counts on the 32 kHz tick,
 interrupt source positions and resource vector widths.
 Assumes the block clock runs at 20 MHz.
*/
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

`define PSC_CLK_HZ 20000000
`define PSC_SLOW_HZ 32000
`define PSC_TICK_DIV (`PSC_CLK_HZ / `PSC_SLOW_HZ)
`define PSC_ON_PULSE_MS 1000
`define PSC_LP_DELAY_MS 6000
`define PSC_TO_OFF_MS 2000
`define PSC_ON_PULSE_TICKS (`PSC_ON_PULSE_MS * `PSC_SLOW_HZ / 1000)
`define PSC_LP_TICKS (`PSC_LP_DELAY_MS * `PSC_SLOW_HZ / 1000)
`define PSC_TO_OFF_TICKS (`PSC_TO_OFF_MS * `PSC_SLOW_HZ / 1000)
`define PSC_DEB_TICKS 3
`define PSC_IRQ_W 8
`define PSC_IRQ_ALARM 0
`define PSC_IRQ_CHARGE 1
`define PSC_IRQ_LONGPRESS 2
`define PSC_IRQ_BUTTON 3
`define PSC_IRQ_HOLD 4
`define PSC_IRQ_GPSYNC 5
`define PSC_RES_W 12
`define PSC_SLOWCLK_BIT 11
`define PSC_CNT_W 18

`endif

/* File: rtl/psc_pkg.sv */
/*
 Types for the power state controller.
 Assumes psc_defines.svh is included where constants are needed.
*/
package psc_pkg;
	typedef enum logic [2:0] {
		PSC_NO_SUPPLY,
		PSC_BACKUP,
		PSC_OFF,
		PSC_ACTIVE,
		PSC_SLEEP
	} psc_state_t;

	typedef enum logic [1:0] {
		PSC_SEQ_A,
		PSC_SEQ_B,
		PSC_SEQ_NVM,
		PSC_SEQ_NONE
	} psc_seq_t;
endpackage

/* File: rtl/psc_power_state_controller.sv */
/*
 Power state controller: supply states, power-on and sleep conditions,
 start-up sequence selection, host reset, interrupt output and enable lines.
 Assumes all inputs are synchronous to clk; the 32 kHz tick is made inside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psc_defines.svh"

module psc_power_state_controller (
	input wire logic clk,
	input wire logic rstn,
	input wire logic supply_backup_ok,
	input wire logic supply_main_ok,
	input wire logic button_on_request,
	input wire logic hold_on_input,
	input wire logic sleep_pin,
	input wire logic sleep_polarity_bit,
	input wire logic stay_on_bit,
	input wire logic shutdown_bit_set,
	input wire logic shutdown_reset_bit,
	input wire logic sleep_allow_bit,
	input wire logic long_press_check_off,
	input wire logic thermal_shutdown,
	input wire logic irq_polarity_bit,
	input wire logic [`PSC_IRQ_W-1:0] irq_mask_reg,
	input wire logic [`PSC_IRQ_W-1:0] irq_clear,
	input wire logic rtc_alarm_event,
	input wire logic battery_high_threshold,
	input wire logic battery_charge_threshold,
	input wire logic gp_sync_event,
	input wire logic seq_select_lo,
	input wire logic seq_select_hi,
	input wire logic slow_clock_enable_bit,
	input wire logic slow_clock_in,
	input wire logic [`PSC_RES_W-1:0] sleep_keep_mask,
	input wire logic [`PSC_RES_W-1:0] line_a_assign,
	input wire logic [`PSC_RES_W-1:0] line_b_assign,
	input wire logic scaling_clock_or_enable_a,
	input wire logic scaling_data_or_enable_b,
	output logic global_reset,
	output logic backup_domain_on,
	output logic slow_osc_on,
	output logic [`PSC_RES_W-1:0] resource_on,
	output logic [`PSC_RES_W-1:0] resource_low_power,
	output logic host_reset_n,
	output logic irq_out,
	output logic [`PSC_IRQ_W-1:0] irq_flags_reg,
	output logic shutdown_bit,
	output logic slow_clock_out,
	output logic serial_port_enable,
	output psc_pkg::psc_state_t power_state,
	output psc_pkg::psc_seq_t boot_sequence
);

	// Helper: any unmasked pending source
	function automatic logic psc_pending(input logic [`PSC_IRQ_W-1:0] f,
		input logic [`PSC_IRQ_W-1:0] m);
		psc_pending = |(f & ~m);
	endfunction

	logic [11:0] tick_cnt;
	logic [11:0] next_tick_cnt;
	logic tick;
	psc_pkg::psc_state_t next_power_state;
	logic [`PSC_IRQ_W-1:0] next_irq_flags_reg;
	logic [`PSC_CNT_W-1:0] press_cnt;
	logic [`PSC_CNT_W-1:0] next_press_cnt;
	logic [`PSC_CNT_W-1:0] pulse_cnt;
	logic [`PSC_CNT_W-1:0] next_pulse_cnt;
	logic [`PSC_CNT_W-1:0] off_cnt;
	logic [`PSC_CNT_W-1:0] next_off_cnt;
	logic [1:0] deb_cnt;
	logic [1:0] next_deb_cnt;
	logic btn_deb;
	logic next_btn_deb;
	logic hold_prev;
	logic sleep_prev;
	logic charge_seen;
	logic next_charge_seen;
	logic next_shutdown_bit;
	logic lp_fired;
	logic next_lp_fired;
	logic [`PSC_IRQ_W-1:0] events;
	logic pending;
	logic pon_disable;
	logic pon_enable;
	logic sleep_level;
	logic sleep_enable;
	logic lines_active;
	logic [`PSC_RES_W-1:0] line_ctrl;
	logic [`PSC_RES_W-1:0] assigned;

	// Slow tick generator stands in for the 32 kHz clock
	always_comb begin
		tick = (tick_cnt == 12'(`PSC_TICK_DIV - 1));
		next_tick_cnt = tick ? 12'h000 : tick_cnt + 12'h001;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tick_cnt <= 12'h000;
		end else begin
			tick_cnt <= next_tick_cnt;
		end
	end

	// Button debounce, long press and unacknowledged press timers
	always_comb begin
		next_deb_cnt = deb_cnt;
		next_btn_deb = btn_deb;
		next_press_cnt = press_cnt;
		next_off_cnt = off_cnt;
		next_lp_fired = lp_fired;
		if (tick) begin
			if (button_on_request == btn_deb) begin
				next_deb_cnt = 2'h0;
			end else if (deb_cnt == 2'(`PSC_DEB_TICKS - 1)) begin
				next_deb_cnt = 2'h0;
				next_btn_deb = button_on_request;
			end else begin
				next_deb_cnt = deb_cnt + 2'h1;
			end
			if (!btn_deb && press_cnt != `PSC_CNT_W'(`PSC_LP_TICKS)) begin
				next_press_cnt = press_cnt + `PSC_CNT_W'(1);
			end
			if (lp_fired && off_cnt != `PSC_CNT_W'(`PSC_TO_OFF_TICKS)) begin
				next_off_cnt = off_cnt + `PSC_CNT_W'(1);
			end
		end
		if (btn_deb) begin
			next_press_cnt = `PSC_CNT_W'(0);
		end
		if (press_cnt == `PSC_CNT_W'(`PSC_LP_TICKS) && !long_press_check_off) begin
			next_lp_fired = 1'b1;
		end
		if (btn_deb || !irq_flags_reg[`PSC_IRQ_LONGPRESS]) begin
			next_lp_fired = next_lp_fired & ~btn_deb;
			if (!irq_flags_reg[`PSC_IRQ_LONGPRESS] && lp_fired) begin
				next_lp_fired = 1'b0;
			end
			next_off_cnt = `PSC_CNT_W'(0);
		end
	end

	// Event sources feeding the flags
	always_comb begin
		events = '0;
		events[`PSC_IRQ_ALARM] = rtc_alarm_event;
		events[`PSC_IRQ_CHARGE] = battery_high_threshold && battery_charge_threshold
			&& !charge_seen;
		events[`PSC_IRQ_LONGPRESS] = (press_cnt == `PSC_CNT_W'(`PSC_LP_TICKS - 1)) && tick
			&& !btn_deb && !long_press_check_off;
		events[`PSC_IRQ_BUTTON] = (!btn_deb && power_state == psc_pkg::PSC_ACTIVE)
			|| (next_btn_deb == 1'b0 && btn_deb);
		events[`PSC_IRQ_HOLD] = hold_on_input && !hold_prev;
		events[`PSC_IRQ_GPSYNC] = gp_sync_event;
		next_charge_seen = charge_seen | events[`PSC_IRQ_CHARGE];
		next_irq_flags_reg = (irq_flags_reg & ~irq_clear) | events;
		pending = psc_pending(irq_flags_reg, irq_mask_reg);
	end

	// Power-on and sleep condition evaluation
	always_comb begin
		pon_disable = lp_fired || thermal_shutdown || shutdown_bit
			|| shutdown_reset_bit;
		pon_enable = !pon_disable && (!btn_deb || hold_on_input || stay_on_bit
			|| (pulse_cnt != `PSC_CNT_W'(0)));
		sleep_level = sleep_polarity_bit ? sleep_pin : !sleep_pin;
		sleep_enable = sleep_level && sleep_allow_bit && !pending;
		// Pulse starts only in off with reset low, then runs its full length
		// so the host has time to take over; clearing the flags ends it early
		next_pulse_cnt = pulse_cnt;
		if (!psc_pending(irq_flags_reg & ~(`PSC_IRQ_W'(1) << `PSC_IRQ_GPSYNC),
			irq_mask_reg)) begin
			next_pulse_cnt = `PSC_CNT_W'(0);
		end else if (power_state == psc_pkg::PSC_OFF && !host_reset_n
			&& pulse_cnt == `PSC_CNT_W'(0)) begin
			next_pulse_cnt = `PSC_CNT_W'(`PSC_ON_PULSE_TICKS);
		end else if (tick && pulse_cnt != `PSC_CNT_W'(0)) begin
			next_pulse_cnt = pulse_cnt - `PSC_CNT_W'(1);
		end
		next_shutdown_bit = shutdown_bit_set
			|| (shutdown_bit && power_state != psc_pkg::PSC_OFF);
	end

	// State transitions
	always_comb begin
		next_power_state = power_state;
		unique case (power_state)
			psc_pkg::PSC_NO_SUPPLY: begin
				if (supply_backup_ok) begin
					next_power_state = psc_pkg::PSC_BACKUP;
				end
			end
			psc_pkg::PSC_BACKUP: begin
				if (supply_main_ok) begin
					next_power_state = psc_pkg::PSC_OFF;
				end
			end
			psc_pkg::PSC_OFF: begin
				if (pon_enable) begin
					next_power_state = psc_pkg::PSC_ACTIVE;
				end
			end
			psc_pkg::PSC_ACTIVE: begin
				if (!pon_enable || off_cnt == `PSC_CNT_W'(`PSC_TO_OFF_TICKS)) begin
					next_power_state = psc_pkg::PSC_OFF;
				end else if (sleep_enable && sleep_level && !sleep_prev) begin
					next_power_state = psc_pkg::PSC_SLEEP;
				end
			end
			psc_pkg::PSC_SLEEP: begin
				if (!pon_enable) begin
					next_power_state = psc_pkg::PSC_OFF;
				end else if (!sleep_level || !btn_deb || pending) begin
					next_power_state = psc_pkg::PSC_ACTIVE;
				end
			end
		endcase
		if (!supply_backup_ok) begin
			next_power_state = psc_pkg::PSC_NO_SUPPLY;
		end else if (!supply_main_ok && power_state != psc_pkg::PSC_NO_SUPPLY) begin
			next_power_state = psc_pkg::PSC_BACKUP;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			power_state <= psc_pkg::PSC_NO_SUPPLY;
			irq_flags_reg <= '0;
			press_cnt <= '0;
			pulse_cnt <= '0;
			off_cnt <= '0;
			deb_cnt <= 2'h0;
			btn_deb <= 1'b1;
			hold_prev <= 1'b0;
			sleep_prev <= 1'b0;
			charge_seen <= 1'b0;
			shutdown_bit <= 1'b0;
			lp_fired <= 1'b0;
		end else begin
			power_state <= next_power_state;
			irq_flags_reg <= next_irq_flags_reg;
			press_cnt <= next_press_cnt;
			pulse_cnt <= next_pulse_cnt;
			off_cnt <= next_off_cnt;
			deb_cnt <= next_deb_cnt;
			btn_deb <= next_btn_deb;
			hold_prev <= hold_on_input;
			sleep_prev <= sleep_level;
			charge_seen <= next_charge_seen;
			shutdown_bit <= next_shutdown_bit;
			lp_fired <= next_lp_fired;
		end
	end

	// Outputs: supplies, reset, clock, enable lines
	always_comb begin
		assigned = line_a_assign | line_b_assign;
		lines_active = host_reset_n && (|assigned);
		line_ctrl = (line_a_assign & {`PSC_RES_W{scaling_clock_or_enable_a}})
			| (line_b_assign & {`PSC_RES_W{scaling_data_or_enable_b}});
		boot_sequence = psc_pkg::PSC_SEQ_NONE;
		unique case ({seq_select_hi, seq_select_lo})
			2'b00: boot_sequence = psc_pkg::PSC_SEQ_A;
			2'b01: boot_sequence = psc_pkg::PSC_SEQ_B;
			2'b10: boot_sequence = psc_pkg::PSC_SEQ_NVM;
			default: boot_sequence = psc_pkg::PSC_SEQ_NONE;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			global_reset <= 1'b1;
			backup_domain_on <= 1'b0;
			slow_osc_on <= 1'b0;
			resource_on <= '0;
			resource_low_power <= '0;
			host_reset_n <= 1'b0;
			irq_out <= 1'b0;
			slow_clock_out <= 1'b0;
			serial_port_enable <= 1'b0;
		end else begin
			global_reset <= (power_state == psc_pkg::PSC_NO_SUPPLY);
			backup_domain_on <= (power_state != psc_pkg::PSC_NO_SUPPLY);
			slow_osc_on <= (power_state != psc_pkg::PSC_NO_SUPPLY);
			host_reset_n <= (power_state == psc_pkg::PSC_ACTIVE)
				|| (power_state == psc_pkg::PSC_SLEEP && host_reset_n);
			irq_out <= pending ^ ~irq_polarity_bit;
			serial_port_enable <= !lines_active;
			resource_low_power <= '0;
			slow_clock_out <= 1'b0;
			unique case (power_state)
				psc_pkg::PSC_ACTIVE: begin
					resource_on <= lines_active ? ((~assigned) | line_ctrl)
						: {`PSC_RES_W{1'b1}};
					slow_clock_out <= slow_clock_in && slow_clock_enable_bit
						&& boot_sequence != psc_pkg::PSC_SEQ_NONE;
				end
				psc_pkg::PSC_SLEEP: begin
					resource_on <= lines_active ? ((sleep_keep_mask & ~assigned) | line_ctrl)
						: sleep_keep_mask;
					resource_low_power <= ~sleep_keep_mask & ~assigned;
					slow_clock_out <= slow_clock_in
						&& sleep_keep_mask[`PSC_SLOWCLK_BIT];
				end
				default: begin
					resource_on <= '0;
				end
			endcase
		end
	end

	// Checks next to the logic
	sequence s_long_press_fire;
		$rose(lp_fired);
	endsequence

	AST_RESET_LOW_OFF: assert property (@(posedge clk) disable iff (!rstn)
		power_state == psc_pkg::PSC_OFF |=> !host_reset_n)
		else $error("host reset high while off");
	AST_NO_SUPPLY_RESET: assert property (@(posedge clk) disable iff (!rstn)
		power_state == psc_pkg::PSC_NO_SUPPLY |=> global_reset && resource_on == '0)
		else $error("no supply without global reset");
	AST_OFF_SUPPLIES: assert property (@(posedge clk) disable iff (!rstn)
		power_state == psc_pkg::PSC_OFF |=> resource_on == '0 && backup_domain_on)
		else $error("supply on in off state");
	AST_DISABLE_OFF: assert property (@(posedge clk) disable iff (!rstn)
		power_state == psc_pkg::PSC_ACTIVE && thermal_shutdown
		|=> power_state == psc_pkg::PSC_OFF || power_state == psc_pkg::PSC_BACKUP
		|| power_state == psc_pkg::PSC_NO_SUPPLY)
		else $error("thermal shutdown ignored");
	AST_SLEEP_NEEDS_ALLOW: assert property (@(posedge clk) disable iff (!rstn)
		power_state == psc_pkg::PSC_ACTIVE && !sleep_allow_bit
		|=> power_state != psc_pkg::PSC_SLEEP)
		else $error("sleep entered without allow bit");
	AST_MASKED_QUIET: assert property (@(posedge clk) disable iff (!rstn)
		(irq_flags_reg & ~irq_mask_reg) == '0 |=> irq_out == !$past(irq_polarity_bit))
		else $error("masked irq drove output");
	AST_FLAG_SET_WINS: assert property (@(posedge clk) disable iff (!rstn)
		events[`PSC_IRQ_HOLD] |=> irq_flags_reg[`PSC_IRQ_HOLD])
		else $error("hold event lost");
	AST_LONG_PRESS_OFF: assert property (@(posedge clk) disable iff (!rstn)
		s_long_press_fire |=> power_state != psc_pkg::PSC_SLEEP)
		else $error("sleep after long press");

endmodule // psc_power_state_controller

`default_nettype wire

/* File: test/psc_host_model.sv */
/*
 Host processor model: acknowledges interrupts by clearing every pending flag.
 Assumes flags and clear pulses share clk with the controller.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psc_defines.svh"
module psc_host_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ack_en,
	input wire logic [`PSC_IRQ_W-1:0] irq_flags_reg,
	output logic [`PSC_IRQ_W-1:0] irq_clear
);
	// Clear all pending flags while acknowledging, else leave them
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			irq_clear <= '0;
		else if (ack_en)
			irq_clear <= irq_flags_reg;
		else
			irq_clear <= '0;
	end
endmodule // psc_host_model
`default_nettype wire

/* File: test/psc_power_state_controller_test.sv */
/*
 Testbench for the power state controller, one task per scenario.
 Assumes default tick and debounce counts; host model clears flags.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psc_defines.svh"
module psc_power_state_controller_test;
	logic clk, rstn, supply_backup_ok, supply_main_ok, button_on_request, hold_on_input;
	logic sleep_pin, sleep_polarity_bit, stay_on_bit, shutdown_bit_set, shutdown_reset_bit;
	logic sleep_allow_bit, long_press_check_off, thermal_shutdown, irq_polarity_bit;
	logic rtc_alarm_event, battery_high_threshold, battery_charge_threshold, gp_sync_event;
	logic seq_select_lo, seq_select_hi, slow_clock_enable_bit, slow_clock_in, ack_en;
	logic scaling_clock_or_enable_a, scaling_data_or_enable_b;
	logic global_reset, backup_domain_on, slow_osc_on, host_reset_n, irq_out;
	logic shutdown_bit, slow_clock_out, serial_port_enable;
	logic [`PSC_IRQ_W-1:0] irq_mask_reg, irq_clear, irq_flags_reg;
	logic [`PSC_RES_W-1:0] sleep_keep_mask, line_a_assign, line_b_assign, resource_on;
	logic [`PSC_RES_W-1:0] resource_low_power;
	psc_pkg::psc_state_t power_state;
	psc_pkg::psc_seq_t boot_sequence;
	int num_errors, n_checks;

	psc_power_state_controller i_psc_power_state_controller (.*);
	psc_host_model i_psc_host_model (.*);

	// Free-running 20 MHz clock
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic final_report();
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Settled sampling points
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Bounded wait for a state
	task automatic wait_st(input psc_pkg::psc_state_t s, input int n);
		n_checks++;
		for (int i = 0; i < n && power_state !== s; i++)
			@(negedge clk);
		if (power_state !== s) begin
			num_errors++;
			$display("MISMATCH t=%0t state wait timed out", $time);
			final_report();
		end
	endtask

	// Host acknowledges everything pending
	task automatic ack();
		@(posedge clk) ack_en <= 1'h1;
		cyc(4);
		@(posedge clk) ack_en <= 1'h0;
		cyc(2);
	endtask

	// Supplies come up: no supply, backup, off
	task automatic t_power_up();
		cyc(2);
		chk(global_reset, 1'h1);
		chk(resource_on, '0);
		@(posedge clk) supply_backup_ok <= 1'h1;
		wait_st(psc_pkg::PSC_BACKUP, 10);
		cyc(2);
		chk(resource_on, '0);
		chk(host_reset_n, 1'h0);
		@(posedge clk) supply_main_ok <= 1'h1;
		wait_st(psc_pkg::PSC_OFF, 10);
		cyc(2);
		chk(backup_domain_on, 1'h1);
		chk(resource_on, '0);
	endtask

	// Every boot pin combination
	task automatic t_boot();
		psc_pkg::psc_seq_t exp [4] = '{psc_pkg::PSC_SEQ_A, psc_pkg::PSC_SEQ_B,
			psc_pkg::PSC_SEQ_NVM, psc_pkg::PSC_SEQ_NONE};
		for (int k = 0; k < 4; k++) begin
			@(posedge clk) {seq_select_hi, seq_select_lo} <= 2'(k);
			@(negedge clk) chk(boot_sequence, exp[k]);
		end
		@(posedge clk) {seq_select_hi, seq_select_lo} <= 2'h0;
	endtask

	// Hold edges move off and active
	task automatic t_hold();
		@(posedge clk) hold_on_input <= 1'h1;
		wait_st(psc_pkg::PSC_ACTIVE, 10);
		cyc(2);
		chk(host_reset_n, 1'h1);
		chk(irq_flags_reg[`PSC_IRQ_HOLD], 1'h1);
		@(posedge clk) hold_on_input <= 1'h0;
		wait_st(psc_pkg::PSC_OFF, 10);
		cyc(2);
		chk(host_reset_n, 1'h0);
		ack();
	endtask

	// Thermal blocks power-on; sync pin does not wake from off
	task automatic t_refuse();
		@(posedge clk) thermal_shutdown <= 1'h1;
		@(posedge clk) hold_on_input <= 1'h1;
		cyc(20);
		chk(power_state, psc_pkg::PSC_OFF);
		@(posedge clk) hold_on_input <= 1'h0;
		@(posedge clk) thermal_shutdown <= 1'h0;
		ack();
		@(posedge clk) irq_mask_reg <= 8'h00;
		gp_sync_event <= 1'h1;
		@(posedge clk) gp_sync_event <= 1'h0;
		cyc(20);
		chk(power_state, psc_pkg::PSC_OFF);
		chk(irq_flags_reg[`PSC_IRQ_GPSYNC], 1'h1);
		ack();
	endtask

	// Alarm and battery rise wake the device; ack lets it drop
	task automatic t_wake();
		@(posedge clk) rtc_alarm_event <= 1'h1;
		@(posedge clk) rtc_alarm_event <= 1'h0;
		wait_st(psc_pkg::PSC_ACTIVE, 20);
		chk(irq_flags_reg[`PSC_IRQ_ALARM], 1'h1);
		ack();
		wait_st(psc_pkg::PSC_OFF, 20);
		@(posedge clk) battery_charge_threshold <= 1'h1;
		battery_high_threshold <= 1'h1;
		wait_st(psc_pkg::PSC_ACTIVE, 4000);
		chk(irq_flags_reg[`PSC_IRQ_CHARGE], 1'h1);
		ack();
		wait_st(psc_pkg::PSC_OFF, 20);
		@(posedge clk) irq_mask_reg <= 8'hFF;
	endtask

	// Sleep needs allow bit; pin edges move active and sleep
	task automatic t_sleep();
		@(posedge clk) stay_on_bit <= 1'h1;
		wait_st(psc_pkg::PSC_ACTIVE, 20);
		@(posedge clk) sleep_pin <= 1'h0;
		cyc(20);
		chk(power_state, psc_pkg::PSC_ACTIVE);
		@(posedge clk) sleep_pin <= 1'h1;
		sleep_allow_bit <= 1'h1;
		@(posedge clk) sleep_pin <= 1'h0;
		wait_st(psc_pkg::PSC_SLEEP, 10);
		cyc(2);
		chk(resource_on, '0);
		chk(resource_low_power, 12'hFFF);
		chk(slow_clock_out, 1'h0);
		@(posedge clk) sleep_pin <= 1'h1;
		wait_st(psc_pkg::PSC_ACTIVE, 10);
	endtask

	// Masking and output polarity
	task automatic t_irq();
		@(posedge clk) irq_mask_reg <= 8'h01;
		irq_polarity_bit <= 1'h1;
		rtc_alarm_event <= 1'h1;
		@(posedge clk) rtc_alarm_event <= 1'h0;
		cyc(3);
		chk(irq_flags_reg[`PSC_IRQ_ALARM], 1'h1);
		chk(irq_out, 1'h0);
		@(posedge clk) irq_mask_reg <= 8'h00;
		cyc(3);
		chk(irq_out, 1'h1);
		@(posedge clk) irq_polarity_bit <= 1'h0;
		cyc(3);
		chk(irq_out, 1'h0);
		ack();
		chk(irq_out, 1'h1);
		@(posedge clk) irq_mask_reg <= 8'hFF;
	endtask

	// Assigning a resource to an enable line turns the serial port off
	task automatic t_lines();
		chk(serial_port_enable, 1'h1);
		@(posedge clk) line_a_assign <= 12'h001;
		cyc(3);
		chk(serial_port_enable, 1'h0);
		chk(resource_on, 12'hFFE);
		@(posedge clk) line_a_assign <= 12'h000;
		line_b_assign <= 12'h800;
		cyc(3);
		chk(serial_port_enable, 1'h0);
		@(posedge clk) line_b_assign <= 12'h000;
	endtask

	// Shutdown bits disable power-on; shutdown bit self-clears
	task automatic t_shutdown();
		@(posedge clk) shutdown_bit_set <= 1'h1;
		@(posedge clk) shutdown_bit_set <= 1'h0;
		wait_st(psc_pkg::PSC_OFF, 10);
		@(posedge clk) stay_on_bit <= 1'h0;
		wait_st(psc_pkg::PSC_OFF, 20);
		cyc(3);
		chk(shutdown_bit, 1'h0);
		@(posedge clk) shutdown_reset_bit <= 1'h1;
		stay_on_bit <= 1'h1;
		cyc(20);
		chk(power_state, psc_pkg::PSC_OFF);
		@(posedge clk) stay_on_bit <= 1'h0;
		@(posedge clk) shutdown_reset_bit <= 1'h0;
	endtask

	// Debounced button press wakes and flags
	task automatic t_button();
		@(posedge clk) button_on_request <= 1'h0;
		wait_st(psc_pkg::PSC_ACTIVE, 4000);
		cyc(2);
		chk(irq_flags_reg[`PSC_IRQ_BUTTON], 1'h1);
		@(posedge clk) button_on_request <= 1'h1;
	endtask

	// Reset, then the scenarios in turn
	initial begin
		rstn = 1'h0;
		{supply_backup_ok, supply_main_ok, hold_on_input, sleep_polarity_bit, stay_on_bit,
			shutdown_bit_set, shutdown_reset_bit, sleep_allow_bit, long_press_check_off,
			thermal_shutdown, irq_polarity_bit, rtc_alarm_event, battery_high_threshold,
			battery_charge_threshold, gp_sync_event, seq_select_lo, seq_select_hi,
			slow_clock_enable_bit, slow_clock_in, ack_en, scaling_clock_or_enable_a,
			scaling_data_or_enable_b, sleep_keep_mask, line_a_assign, line_b_assign} = '0;
		button_on_request = 1'h1;
		sleep_pin = 1'h1;
		irq_mask_reg = 8'hFF;
		num_errors = 0;
		n_checks = 0;
		repeat (16) @(posedge clk);
		rstn <= 1'h1;
		t_power_up();
		t_boot();
		t_hold();
		t_refuse();
		t_wake();
		t_sleep();
		t_irq();
		t_lines();
		t_shutdown();
		t_button();
		final_report();
	end
endmodule // psc_power_state_controller_test
`default_nettype wire
